// ==== buzzer_load.sv ====
// partner model: external buzzer on the shared pad, plus an outside source
// assumes active-low pad enable and a single clock for everything
`timescale 1ns/1ps
module buzzer_load (
  input wire logic clk,
  input wire logic pin_out, // pad output level
  input wire logic pin_oe_n, // pad enable, low drives
  input wire logic ext_level, // level held by the board when undriven
  output logic pad, // resolved wire level
  output logic [15:0] period, // cycles between rising edges
  output logic [15:0] high // cycles the tone stays high
);
  logic prev = 1'b0; // pad level one edge ago
  logic [15:0] rcnt = 16'h0000; // cycles since last rise
  // buzzer is a passive load, so the wire is the driver or the board
  assign pad = pin_oe_n ? ext_level : pin_out;
  // pitch heard is what software set up; measured, not judged here
  always @(posedge clk) begin
    prev <= pad;
    if (pad && !prev) begin
      period <= rcnt;
      rcnt <= 16'h0001;
    end else begin
      rcnt <= rcnt + 16'h0001;
    end
    if (!pad && prev) begin
      high <= rcnt;
    end
  end
endmodule

// ==== buzzer_tone_generator.sv ====
// buzzer tone generator: divides the instruction-cycle clock and drives a
// square wave onto a pin shared with general-purpose I/O.
// assumes clk is the instruction-cycle clock, rst synchronous active high,
// and the port logic supplies its own drive level and direction on this clock.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module buzzer_tone_generator #(
  parameter int COUNT_W = tone_pkg::COUNT_WIDTH // divider counter width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_write, // one-cycle write strobe
  input wire logic reg_read, // one-cycle read strobe
  output logic [7:0] reg_rdata, // read data, cycle after the strobe
  input wire logic gpio_drive_level, // level the port would drive
  input wire logic gpio_drive_enable, // high when the port is in output mode
  output logic gpio_pin_level, // synchronised pin level back to the port
  input wire logic shared_port_pin_in, // pad input
  output logic shared_port_pin_out, // pad output level
  output logic shared_port_pin_oe_n // pad output enable, low drives
);

  // control register state
  logic tone_output_enable; // bit 7
  logic [1:0] tone_divider_select; // bits 6:5
  logic next_tone_output_enable;
  logic [1:0] next_tone_divider_select;

  // divider state
  logic [COUNT_W-1:0] count; // free-running while enabled
  logic [COUNT_W-1:0] next_count;
  logic [3:0] tone_index; // counter bit that carries the tone
  logic tone_output; // current square-wave level
  logic [COUNT_W-1:0] low_mask; // bits below the tone bit

  // pad and synchroniser state
  logic pin_sync_first; // read only by pin_sync_second
  logic pin_sync_second; // safe to use
  logic next_pin_out;
  logic next_pin_oe_n;
  logic next_gpio_pin_level;
  logic [7:0] next_rdata;

  // register next values: writes only land on the control address
  always_comb begin
    next_tone_output_enable = tone_output_enable;
    next_tone_divider_select = tone_divider_select;
    if (reg_write && reg_addr == tone_pkg::TONE_CONTROL_ADDR) begin
      next_tone_output_enable = reg_wdata[tone_pkg::ENABLE_POS];
      next_tone_divider_select = reg_wdata[tone_pkg::SELECT_HI_POS:tone_pkg::SELECT_LO_POS];
    end
  end

  // control register flops
  always_ff @(posedge clk) begin
    if (rst) begin
      tone_output_enable <= tone_pkg::ENABLE_RESET;
      tone_divider_select <= tone_pkg::SELECT_RESET;
    end else begin
      tone_output_enable <= next_tone_output_enable;
      tone_divider_select <= next_tone_divider_select;
    end
  end

  // tone bit selection: bit k of a binary counter toggles every 2**k cycles,
  // so bit 7+select gives a period of 256 << select with equal halves
  always_comb begin
    tone_index = tone_pkg::TONE_LSB_INDEX + {2'h0, tone_divider_select};
    tone_output = count[tone_index];
    low_mask = COUNT_W'((11'h001 << tone_index) - 11'h001);
  end

  // divider next value: held at zero while off so each tone starts low
  always_comb begin
    if (tone_output_enable) begin
      next_count = COUNT_W'(count + 11'h001);
    end else begin
      next_count = COUNT_W'(tone_pkg::COUNT_RESET);
    end
  end

  // divider flops
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= COUNT_W'(tone_pkg::COUNT_RESET);
    end else begin
      count <= next_count;
    end
  end

  // pad mux and read data next values
  always_comb begin
    // tone owns the pad while enabled, else the port's own setting comes back
    if (tone_output_enable) begin
      next_pin_out = tone_output;
      next_pin_oe_n = 1'h0;
      next_gpio_pin_level = gpio_pin_level; // port input isolated, holds last
    end else begin
      next_pin_out = gpio_drive_level;
      next_pin_oe_n = ~gpio_drive_enable;
      next_gpio_pin_level = pin_sync_second;
    end
    // read data stands for exactly one cycle after the strobe
    next_rdata = tone_pkg::RDATA_RESET;
    if (reg_read) begin
      unique case (reg_addr)
        tone_pkg::TONE_CONTROL_ADDR: begin
          next_rdata[tone_pkg::ENABLE_POS] = tone_output_enable;
          next_rdata[tone_pkg::SELECT_HI_POS:tone_pkg::SELECT_LO_POS] = tone_divider_select;
        end
        tone_pkg::TONE_STATUS_ADDR: begin
          next_rdata[tone_pkg::STATUS_TONE_POS] = tone_output;
          next_rdata[tone_pkg::STATUS_PIN_POS] = pin_sync_second;
        end
        // unmapped addresses read as zero
        default: begin
          next_rdata = tone_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  // pad, synchroniser and read data flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync_first <= 1'h0;
      pin_sync_second <= 1'h0;
      shared_port_pin_out <= 1'h0;
      shared_port_pin_oe_n <= 1'h1; // released until the port decides
      gpio_pin_level <= 1'h0;
      reg_rdata <= tone_pkg::RDATA_RESET;
    end else begin
      pin_sync_first <= shared_port_pin_in;
      pin_sync_second <= pin_sync_first;
      shared_port_pin_out <= next_pin_out;
      shared_port_pin_oe_n <= next_pin_oe_n;
      gpio_pin_level <= next_gpio_pin_level;
      reg_rdata <= next_rdata;
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // tone bit is about to flip: all bits below it are ones
  sequence s_low_full;
    tone_output_enable && ((count & low_mask) == low_mask);
  endsequence

  // tone bit must hold: not at the flip point
  sequence s_low_partial;
    tone_output_enable && ((count & low_mask) != low_mask);
  endsequence

  // still enabled, rate unchanged since the cycle before
  sequence s_still_running;
    tone_output_enable && $stable(tone_divider_select);
  endsequence

  a_tone_edge_flips: assert property (
    s_low_full ##1 s_still_running |-> tone_output != $past(tone_output))
    else $error("tone did not toggle at half period");

  a_tone_holds_between: assert property (
    s_low_partial ##1 s_still_running |-> tone_output == $past(tone_output))
    else $error("tone changed inside a half period");

  a_disabled_counter_clear: assert property (
    !tone_output_enable |=> count == tone_pkg::COUNT_RESET && !tone_output)
    else $error("divider not cleared while disabled");

  a_tone_drives_pin: assert property (
    tone_output_enable |=> !shared_port_pin_oe_n && shared_port_pin_out == $past(tone_output))
    else $error("tone not driven onto shared pin");

  a_gpio_state_returns: assert property (
    !tone_output_enable |=> shared_port_pin_out == $past(gpio_drive_level)
      && shared_port_pin_oe_n == !$past(gpio_drive_enable))
    else $error("pin did not return to port state");

  a_gpio_input_isolated: assert property (
    tone_output_enable |=> $stable(gpio_pin_level))
    else $error("port input not isolated while tone on");

  a_control_write_lands: assert property (
    reg_write && reg_addr == tone_pkg::TONE_CONTROL_ADDR |=>
      tone_output_enable == $past(reg_wdata[7]) && tone_divider_select == $past(reg_wdata[6:5]))
    else $error("control write did not land in bits 7 to 5");

  a_control_read_back: assert property (
    reg_read && reg_addr == tone_pkg::TONE_CONTROL_ADDR |=>
      reg_rdata == {$past(tone_output_enable), $past(tone_divider_select), 5'h00})
    else $error("control read back wrong or unused bits set");

  // register port side effects, start-up of the tone and port input return while off
  a_other_write_ignored: assert property (
    reg_write && reg_addr != tone_pkg::TONE_CONTROL_ADDR |=>
      $stable(tone_output_enable) && $stable(tone_divider_select))
    else $error("write to another address changed the control bits");

  a_rdata_one_cycle: assert property (
    !reg_read |=> reg_rdata == tone_pkg::RDATA_RESET)
    else $error("read data stood longer than one cycle");

  a_tone_starts_low: assert property (
    $rose(tone_output_enable) |-> count == tone_pkg::COUNT_RESET && !tone_output)
    else $error("tone did not start from a cleared divider");

  a_gpio_level_follows: assert property (
    !tone_output_enable |=> gpio_pin_level == $past(pin_sync_second))
    else $error("port input not returned while tone off");

endmodule

// ==== tb.sv ====
// testbench for the buzzer tone generator with its pad and buzzer model
// assumes register reads answer one cycle after the strobe
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic gpio_drive_level = 1'b0; // port wish
  logic gpio_drive_enable = 1'b0; // port direction
  logic ext_level = 1'b0; // board level on an idle pad
  logic gpio_pin_level, pin_out, pin_oe_n, pad;
  logic [15:0] period, high; // measured by the buzzer model
  logic [7:0] v; // random control value
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0; // hang guard
  always #4 clk = ~clk;
  buzzer_tone_generator i_buzzer_tone_generator (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .gpio_drive_level(gpio_drive_level), .gpio_drive_enable(gpio_drive_enable),
    .gpio_pin_level(gpio_pin_level), .shared_port_pin_in(pad), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe_n(pin_oe_n));
  buzzer_load i_buzzer_load (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pad(pad), .period(period), .high(high));
  // one comparison, counted
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // control bits that survive a write: enable and select only
  function automatic logic [7:0] ctrl_view(input logic [7:0] d);
    return d & 8'hE0;
  endfunction
  // half period of the tone for a given divider select
  function automatic logic [15:0] half_period(input int s);
    return 16'(128 << s);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // write: one strobe cycle, then a spare edge so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  // read: data looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check("read data", reg_rdata, exp);
    @(posedge clk);
  endtask
  // hang guard, well above the longest tone sweep
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(68786));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'hDC, 8'h00);
    rd(8'h10, 8'h00);
    // random control values, reserved bits must read back 0
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(8'hDC, v);
      rd(8'hDC, ctrl_view(v));
      wr(8'hDB, ~v);
      rd(8'hDC, ctrl_view(v));
    end
    // every divider ratio, then back to the port's own setting
    for (int s = 0; s < 4; s++) begin
      gpio_drive_level <= 1'($urandom);
      gpio_drive_enable <= 1'($urandom);
      ext_level <= 1'($urandom);
      wr(8'hDC, {1'b1, 2'(s), 5'h1F});
      repeat (3 * (256 << s)) @(posedge clk);
      #1;
      check("pad enable", pin_oe_n, 1'b0);
      check("tone period", period, 16'(2 * half_period(s)));
      check("tone high", high, half_period(s));
      @(posedge clk);
      wr(8'hDC, {1'b0, 2'(s), 5'h00});
      #1;
      check("pad level", pin_out, gpio_drive_level);
      check("pad dir", pin_oe_n, !gpio_drive_enable);
      repeat (4) @(posedge clk);
      #1;
      check("pin back", gpio_pin_level, pad);
      @(posedge clk);
      rd(8'hDD, {6'h00, pad, 1'b0});
    end
    finish_test();
  end
endmodule

// ==== tone_pkg.sv ====
// constants shared by the buzzer tone generator: register map, field layout,
// reset values and divider geometry.
// assumes one 8-bit register port on the instruction-cycle clock.
package tone_pkg;

  // register addresses on the 8-bit register port
  localparam logic [7:0] TONE_CONTROL_ADDR = 8'hDC; // enable and divider select
  localparam logic [7:0] TONE_STATUS_ADDR = 8'hDD; // read-only live state

  // field positions inside the control register
  localparam int ENABLE_POS = 7; // tone output enable
  localparam int SELECT_HI_POS = 6; // divider select, upper bit
  localparam int SELECT_LO_POS = 5; // divider select, lower bit

  // field positions inside the status register
  localparam int STATUS_TONE_POS = 0; // current tone level
  localparam int STATUS_PIN_POS = 1; // synchronised pin level

  // values after reset
  localparam logic ENABLE_RESET = 1'h0; // tone off
  localparam logic [1:0] SELECT_RESET = 2'h0; // divide by 256
  localparam logic [7:0] RDATA_RESET = 8'h00; // read data idle value

  // divider geometry: select 0 divides by 2**8, each step doubles
  localparam int DIV_BASE_LOG2 = 8; // 256 cycles per tone period
  localparam int COUNT_WIDTH = 11; // enough for 2048
  localparam logic [3:0] TONE_LSB_INDEX = 4'h7; // half period of 256 is bit 7
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 11'h000; // divider cleared

endpackage
